// ### idp_defines.svh
// Offsets, field positions, reset values and timing counts of the dispatch block
`ifndef IDP_DEFINES_SVH
`define IDP_DEFINES_SVH
`define IDP_OFF_POWER_CTRL 8'h87
`define IDP_OFF_IRQ_LEVEL_EXTRA 8'hB7
`define IDP_OFF_IRQ_LEVEL_MAIN 8'hB8
`define IDP_OFF_IRQ_MASK_EXTRA 8'hA7
`define IDP_OFF_IRQ_MASK_MAIN 8'hA8
`define IDP_OFF_STATUS 8'hC0
`define IDP_POWER_CTRL_RESET 8'h00
`define IDP_LEVEL_EXTRA_MASK 8'h13
`define IDP_LEVEL_MAIN_MASK 8'h3F
`define IDP_MASK_EXTRA_MASK 8'h13
`define IDP_MASK_MAIN_MASK 8'hBF
`define IDP_BIT_SLEEP_CPU 0
`define IDP_BIT_DEEP_SLEEP 1
`define IDP_BIT_UART2_TX_SEL 2
`define IDP_BIT_UART2_RX_SEL 3
`define IDP_BIT_ADC_IRQ_EN 4
`define IDP_BIT_SUPPLY_RST_DIS 5
`define IDP_BIT_BAUD_SECOND 6
`define IDP_BIT_BAUD_FIRST 7
`define IDP_BIT_GLOBAL_GATE 7
`define IDP_PHASES_PER_CYCLE 12
`define IDP_SAMPLE_PHASE 9
`define IDP_INT_RESTART_CYCLES 3
`define IDP_NUM_SRC 10
`endif

// ### idp_pkg.sv
// Types shared by the interrupt dispatch block
package idp_pkg;
    typedef enum logic [1:0] {
        IDP_RUN,
        IDP_IDLE,
        IDP_DEEP,
        IDP_RESTART
    } idp_mode_t;
endpackage

// ### idp_dispatch.sv
// Interrupt dispatch, priority registers and power-mode control
//
// Notes on behaviour
// - Extra level register: bits 4,1,0 only
// - Sample flags at sample phase, poll same cycle
// - Unblocked polled flag produces vector call
// - Block while same or higher in progress
// - Call only at instruction's last cycle; in idle at any machine-cycle end
// - Block on exit or level/mask access
// - Blocked requests are not remembered
// - Acknowledge marks level in progress, PC pushed
// - Fixed vector address per source
// - Irq exit clears current in-progress level
// - Plain return leaves in-progress set
// - Idle halts only the CPU
// - Idle write last instruction, state kept
// - Enabled interrupt clears idle bit
// - Internal reset restarts after three cycles
// - Deep sleep stops clock, units disabled
// - Deep sleep left only by reset
// - Low-supply detector stays active
// - Power control layout, reset 00
// - Level bit 0 low, 1 high
// - Fixed polling order within level
// - Individual enable and global gate required
`timescale 1ns/100ps
`default_nettype none
`include "idp_defines.svh"

module idp_dispatch
    import idp_pkg::*;
#(
    parameter int NSRC = `IDP_NUM_SRC,
    parameter int PHASES = `IDP_PHASES_PER_CYCLE,
    parameter int RESTART_CYCLES = `IDP_INT_RESTART_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NSRC-1:0] irq_flags,
    input wire logic instr_last_cycle,
    input wire logic instr_is_irq_exit,
    input wire logic instr_is_plain_sub_exit,
    input wire logic instr_touches_irq_regs,
    input wire logic internal_reset_req,
    output logic long_vector_call,
    output logic [15:0] vector_addr,
    output logic [3:0] vector_src,
    output logic cpu_halt,
    output logic periph_clock_stop,
    output logic deep_units_disable,
    output logic low_supply_detector_on,
    output logic baud_doubler_first,
    output logic baud_doubler_second,
    output logic supply_reset_disable,
    output logic adc_irq_enable,
    output logic uart2_rx_timer_sel,
    output logic uart2_tx_timer_sel
);
    // Source index is polling order: 0 ext0, 1 uart2, 2 tmr0, 3 twi, 4 ext1,
    // 5 reserved, 6 tmr1, 7 usb, 8 uart1, 9 tmr2
    localparam int PW = $clog2(PHASES);
    localparam int RW = $clog2(RESTART_CYCLES + 1);

    function automatic logic [15:0] vec_of(input logic [3:0] s);
        case (s)
            4'h0: vec_of = 16'h0003;
            4'h1: vec_of = 16'h004B;
            4'h2: vec_of = 16'h000B;
            4'h3: vec_of = 16'h0043;
            4'h4: vec_of = 16'h0013;
            4'h6: vec_of = 16'h001B;
            4'h7: vec_of = 16'h0033;
            4'h8: vec_of = 16'h0023;
            4'h9: vec_of = 16'h002B;
            default: vec_of = 16'h0000;
        endcase
    endfunction

    logic [7:0] power_ctrl_reg;
    logic [7:0] irq_level_extra_reg;
    logic [7:0] irq_level_main_reg;
    logic [7:0] irq_mask_extra_reg;
    logic [7:0] irq_mask_main_reg;
    logic [1:0] in_progress_reg;
    logic [NSRC-1:0] sample_reg;
    logic [PW-1:0] phase_reg;
    logic [RW-1:0] restart_reg;
    idp_mode_t mode_reg;

    // Bus slave
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;
    logic wr_hit;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr[9:2];
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `IDP_OFF_POWER_CTRL) || (a == `IDP_OFF_IRQ_LEVEL_EXTRA) ||
            (a == `IDP_OFF_IRQ_LEVEL_MAIN) || (a == `IDP_OFF_IRQ_MASK_EXTRA) ||
            (a == `IDP_OFF_IRQ_MASK_MAIN) || (a == `IDP_OFF_STATUS);
    endfunction

    assign wr_hit = mapped(aw_addr_reg);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr[9:2]) ? 2'b00 : 2'b10;
                case (s_axi_araddr[9:2])
                    `IDP_OFF_POWER_CTRL: s_axi_rdata <= {24'h00_0000, power_ctrl_reg};
                    `IDP_OFF_IRQ_LEVEL_EXTRA: s_axi_rdata <= {24'h00_0000, irq_level_extra_reg};
                    `IDP_OFF_IRQ_LEVEL_MAIN: s_axi_rdata <= {24'h00_0000, irq_level_main_reg};
                    `IDP_OFF_IRQ_MASK_EXTRA: s_axi_rdata <= {24'h00_0000, irq_mask_extra_reg};
                    `IDP_OFF_IRQ_MASK_MAIN: s_axi_rdata <= {24'h00_0000, irq_mask_main_reg};
                    `IDP_OFF_STATUS: s_axi_rdata <= {20'h0_0000, vector_src, 2'b00, mode_reg, 2'b00, in_progress_reg};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Machine-cycle phase counter; frozen in deep sleep as the oscillator stops
    logic sample_now;
    logic cycle_end;
    assign sample_now = (phase_reg == PW'(`IDP_SAMPLE_PHASE));
    assign cycle_end = (phase_reg == PW'(PHASES - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_reg <= '0;
        end else if (mode_reg != IDP_DEEP) begin
            phase_reg <= cycle_end ? '0 : phase_reg + 1'b1;
        end
    end

    // Fresh samples each cycle; nothing carried over from a blocked poll
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_reg <= '0;
        end else if (sample_now && mode_reg != IDP_DEEP) begin
            sample_reg <= irq_flags;
        end
    end

    // Enable and level vectors in polling order
    logic [NSRC-1:0] enabled;
    logic [NSRC-1:0] level_hi;
    assign enabled = {irq_mask_main_reg[5], irq_mask_main_reg[4], irq_mask_extra_reg[0],
        irq_mask_main_reg[3], 1'b0, irq_mask_main_reg[2], irq_mask_extra_reg[1],
        irq_mask_main_reg[1], irq_mask_extra_reg[4], irq_mask_main_reg[0]};
    assign level_hi = {irq_level_main_reg[5], irq_level_main_reg[4], irq_level_extra_reg[0],
        irq_level_main_reg[3], 1'b0, irq_level_main_reg[2], irq_level_extra_reg[1],
        irq_level_main_reg[1], irq_level_extra_reg[4], irq_level_main_reg[0]};

    logic [NSRC-1:0] pending;
    logic [NSRC-1:0] cand_hi;
    logic [NSRC-1:0] cand_lo;
    logic [3:0] pick;
    logic pick_hi;
    logic pick_ok;
    assign pending = sample_reg & enabled & {NSRC{irq_mask_main_reg[`IDP_BIT_GLOBAL_GATE]}};
    assign cand_hi = pending & level_hi;
    assign cand_lo = pending & ~level_hi;

    always_comb begin
        pick = 4'h0;
        pick_hi = 1'b0;
        pick_ok = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (cand_hi[i]) begin
                pick = 4'(i);
                pick_hi = 1'b1;
                pick_ok = 1'b1;
            end
        end
        if (!pick_ok) begin
            for (int i = NSRC - 1; i >= 0; i--) begin
                if (cand_lo[i]) begin
                    pick = 4'(i);
                    pick_ok = 1'b1;
                end
            end
        end
        if (pick_ok && (in_progress_reg[1] || (!pick_hi && in_progress_reg[0]))) begin
            pick_ok = 1'b0;
        end
    end

    logic dispatch;
    // Polling at the end of the same machine cycle as the sample; idle CPU has no instruction
    assign dispatch = cycle_end && pick_ok && (mode_reg == IDP_RUN || mode_reg == IDP_IDLE) &&
        (mode_reg == IDP_IDLE || (instr_last_cycle && !instr_is_irq_exit &&
        !instr_touches_irq_regs));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            long_vector_call <= 1'b0;
            vector_addr <= 16'h0000;
            vector_src <= 4'h0;
        end else begin
            long_vector_call <= dispatch;
            if (dispatch) begin
                vector_addr <= vec_of(pick);
                vector_src <= pick;
            end
        end
    end

    // Plain returns are ignored here on purpose
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_progress_reg <= 2'b00;
        end else if (dispatch) begin
            in_progress_reg[pick_hi] <= 1'b1;
        end else if (cycle_end && instr_last_cycle && instr_is_irq_exit && mode_reg == IDP_RUN) begin
            if (in_progress_reg[1]) begin
                in_progress_reg[1] <= 1'b0;
            end else begin
                in_progress_reg[0] <= 1'b0;
            end
        end
    end

    // Registers; writes land only in run mode, so dispatch clearing the idle bit never meets a same-cycle write
    logic [7:0] wd;
    assign wd = w_data_reg[7:0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_ctrl_reg <= `IDP_POWER_CTRL_RESET;
            irq_level_extra_reg <= 8'h00;
            irq_level_main_reg <= 8'h00;
            irq_mask_extra_reg <= 8'h00;
            irq_mask_main_reg <= 8'h00;
        end else begin
            if (wr_fire && w_strb_reg[0] && mode_reg == IDP_RUN) begin
                case (aw_addr_reg)
                    `IDP_OFF_POWER_CTRL: power_ctrl_reg <= wd;
                    `IDP_OFF_IRQ_LEVEL_EXTRA: irq_level_extra_reg <= wd & `IDP_LEVEL_EXTRA_MASK;
                    `IDP_OFF_IRQ_LEVEL_MAIN: irq_level_main_reg <= wd & `IDP_LEVEL_MAIN_MASK;
                    `IDP_OFF_IRQ_MASK_EXTRA: irq_mask_extra_reg <= wd & `IDP_MASK_EXTRA_MASK;
                    `IDP_OFF_IRQ_MASK_MAIN: irq_mask_main_reg <= wd & `IDP_MASK_MAIN_MASK;
                    default: ;
                endcase
            end
            if (dispatch && mode_reg == IDP_IDLE) begin
                power_ctrl_reg[`IDP_BIT_SLEEP_CPU] <= 1'b0;
            end
            // Internal reset drops any sleep request, else restart falls back to idle
            if (mode_reg == IDP_RESTART) begin
                power_ctrl_reg <= `IDP_POWER_CTRL_RESET;
            end
        end
    end

    // Power-mode sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= IDP_RUN;
            restart_reg <= '0;
        end else begin
            case (mode_reg)
                IDP_RUN: begin
                    if (internal_reset_req) begin
                        mode_reg <= IDP_RESTART;
                        restart_reg <= '0;
                    end else if (power_ctrl_reg[`IDP_BIT_DEEP_SLEEP]) begin
                        mode_reg <= IDP_DEEP;
                    end else if (power_ctrl_reg[`IDP_BIT_SLEEP_CPU]) begin
                        mode_reg <= IDP_IDLE;
                    end
                end
                IDP_IDLE: begin
                    if (internal_reset_req) begin
                        mode_reg <= IDP_RESTART;
                        restart_reg <= '0;
                    end else if (dispatch) begin
                        mode_reg <= IDP_RUN;
                    end
                end
                IDP_DEEP: begin
                    mode_reg <= IDP_DEEP;
                end
                IDP_RESTART: begin
                    if (cycle_end) begin
                        if (restart_reg == RW'(RESTART_CYCLES - 1)) begin
                            mode_reg <= IDP_RUN;
                        end
                        restart_reg <= restart_reg + 1'b1;
                    end
                end
                default: mode_reg <= IDP_RUN;
            endcase
        end
    end

    // External reset length is the source's duty rst is taken as is
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_halt <= 1'b0;
            periph_clock_stop <= 1'b0;
            deep_units_disable <= 1'b0;
            low_supply_detector_on <= 1'b1;
            baud_doubler_first <= 1'b0;
            baud_doubler_second <= 1'b0;
            supply_reset_disable <= 1'b0;
            adc_irq_enable <= 1'b0;
            uart2_rx_timer_sel <= 1'b0;
            uart2_tx_timer_sel <= 1'b0;
        end else begin
            cpu_halt <= (mode_reg != IDP_RUN);
            periph_clock_stop <= (mode_reg == IDP_DEEP);
            deep_units_disable <= (mode_reg == IDP_DEEP);
            low_supply_detector_on <= 1'b1;
            baud_doubler_first <= power_ctrl_reg[`IDP_BIT_BAUD_FIRST];
            baud_doubler_second <= power_ctrl_reg[`IDP_BIT_BAUD_SECOND];
            supply_reset_disable <= power_ctrl_reg[`IDP_BIT_SUPPLY_RST_DIS];
            adc_irq_enable <= power_ctrl_reg[`IDP_BIT_ADC_IRQ_EN];
            uart2_rx_timer_sel <= power_ctrl_reg[`IDP_BIT_UART2_RX_SEL];
            uart2_tx_timer_sel <= power_ctrl_reg[`IDP_BIT_UART2_TX_SEL];
        end
    end
endmodule // idp_dispatch
`default_nettype wire

// ### idp_dispatch_sva.sv
// Port-level checker for the interrupt dispatch block
`timescale 1ns/100ps
`default_nettype none
module idp_dispatch_chk #(
    parameter int NSRC = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [NSRC-1:0] irq_flags,
    input wire logic instr_last_cycle,
    input wire logic instr_is_irq_exit,
    input wire logic instr_touches_irq_regs,
    input wire logic long_vector_call,
    input wire logic [15:0] vector_addr,
    input wire logic [3:0] vector_src,
    input wire logic cpu_halt,
    input wire logic periph_clock_stop,
    input wire logic deep_units_disable,
    input wire logic low_supply_detector_on,
    input wire logic baud_doubler_first,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    // Slot 5 is reserved and never vectored
    localparam logic [15:0] VEC [10] = '{16'h0003, 16'h004B, 16'h000B, 16'h0043, 16'h0013,
        16'h0000, 16'h001B, 16'h0033, 16'h0023, 16'h002B};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_detector_on: assert property (low_supply_detector_on)
        else $error("supply detector off");
    a_call_pulse: assert property (long_vector_call |=> !long_vector_call [*8])
        else $error("call repeated inside a machine cycle");
    // Sample depth allowed to vary by a clock either way
    a_call_flag: assert property (long_vector_call |-> |((($past(irq_flags, 2) | $past(irq_flags, 3)
        | $past(irq_flags, 4)) >> vector_src) & NSRC'(1))) else $error("call without sampled flag");
    a_vector_map: assert property (long_vector_call |-> vector_addr == VEC[vector_src])
        else $error("wrong vector address");
    a_call_gate: assert property (long_vector_call |-> $past(cpu_halt) || ($past(instr_last_cycle)
        && !$past(instr_is_irq_exit) && !$past(instr_touches_irq_regs))) else $error("call while blocked");
    a_idle_cpu_only: assert property (cpu_halt && !periph_clock_stop |-> !deep_units_disable)
        else $error("units disabled in idle");
    a_deep_units: assert property (periph_clock_stop |-> deep_units_disable)
        else $error("units running in deep sleep");
    a_deep_stays: assert property (periph_clock_stop |=> periph_clock_stop && !long_vector_call)
        else $error("deep sleep left without reset");
    a_reset_clear: assert property (disable iff (1'b0) rst |=> !baud_doubler_first && !cpu_halt
        && !long_vector_call) else $error("outputs set during reset");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    c_call: cover property (long_vector_call);
    c_idle: cover property (cpu_halt && !periph_clock_stop);
    c_deep: cover property (periph_clock_stop);
endmodule // idp_dispatch_chk
bind idp_dispatch idp_dispatch_chk #(.NSRC(NSRC)) idp_dispatch_chk_i (.clk(clk), .rst(rst),
    .irq_flags(irq_flags), .instr_last_cycle(instr_last_cycle), .instr_is_irq_exit(instr_is_irq_exit),
    .instr_touches_irq_regs(instr_touches_irq_regs), .long_vector_call(long_vector_call),
    .vector_addr(vector_addr), .vector_src(vector_src), .cpu_halt(cpu_halt),
    .periph_clock_stop(periph_clock_stop), .deep_units_disable(deep_units_disable),
    .low_supply_detector_on(low_supply_detector_on), .baud_doubler_first(baud_doubler_first),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
`default_nettype wire

// ### idp_cpu_model.sv
// Sequencer stand-in: tracks calls and plays the interrupt return
`timescale 1ns/100ps
`default_nettype none
module idp_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic call,
    input wire logic ret_req,
    output logic irq_exit,
    output logic [3:0] depth
);
    logic [3:0] cnt_reg;
    // Return held a full machine cycle so one poll surely sees it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            depth <= '0;
        end else begin
            if (call) depth <= depth + 4'h1;
            if (ret_req && cnt_reg == 4'h0) cnt_reg <= 4'hC;
            else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
            if (cnt_reg == 4'h1) depth <= depth - 4'h1;
        end
    end
    assign irq_exit = cnt_reg != 4'h0;
endmodule // idp_cpu_model
`default_nettype wire

// ### interrupt_dispatch_power_modes_tb.sv
// Self-checking bench for the interrupt dispatch block
`timescale 1ns/100ps
`default_nettype none
module interrupt_dispatch_power_modes_tb;
    typedef struct {logic [9:0] f; logic [3:0] s; logic [15:0] v;} idp_row_t;
    idp_row_t rows [11] = '{'{10'h001, 4'h0, 16'h0003}, '{10'h002, 4'h1, 16'h004B},
        '{10'h004, 4'h2, 16'h000B}, '{10'h008, 4'h3, 16'h0043}, '{10'h010, 4'h4, 16'h0013},
        '{10'h040, 4'h6, 16'h001B}, '{10'h080, 4'h7, 16'h0033}, '{10'h100, 4'h8, 16'h0023},
        '{10'h200, 4'h9, 16'h002B}, '{10'h3FF, 4'h0, 16'h0003}, '{10'h3E0, 4'h6, 16'h001B}};
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [31:0] aw = '0, wd = '0, ar = '0, rd, q;
    logic [9:0] flags = '0;
    logic last = 1'b1, sub = 1'b0, touch = 1'b0, irr = 1'b0, rreq = 1'b0, got, rx_exit;
    logic awr, wr, bv, arr, rv, call, halt, pstop, udis, lsd, bf, bs, srd, adc, rxs, txs;
    logic [1:0] brs, rrs, rs;
    logic [15:0] vaddr;
    logic [3:0] vsrc, depth;
    int fail_count = 0;
    int cmp_count = 0;
    always #2.5 clk = ~clk;
    idp_dispatch idp_dispatch_i (.clk(clk), .rst(rst), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .irq_flags(flags), .instr_last_cycle(last), .instr_is_irq_exit(rx_exit),
        .instr_is_plain_sub_exit(sub), .instr_touches_irq_regs(touch), .internal_reset_req(irr),
        .long_vector_call(call), .vector_addr(vaddr), .vector_src(vsrc), .cpu_halt(halt),
        .periph_clock_stop(pstop), .deep_units_disable(udis), .low_supply_detector_on(lsd),
        .baud_doubler_first(bf), .baud_doubler_second(bs), .supply_reset_disable(srd),
        .adc_irq_enable(adc), .uart2_rx_timer_sel(rxs), .uart2_tx_timer_sel(txs));
    idp_cpu_model idp_cpu_model_i (.clk(clk), .rst(rst), .call(call), .ret_req(rreq),
        .irq_exit(rx_exit), .depth(depth));
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Register index times four gives the byte address
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, tr;
        @(posedge clk);
        if (w) begin
            aw <= {22'h0, a, 2'b00};
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            br <= 1'b1;
        end else begin
            ar <= {22'h0, a, 2'b00};
            arv <= 1'b1;
            rr <= 1'b1;
        end
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            if (w ? (bv && !awv && !wv) : (rv && !arv)) break;
            ta = awv & awr;
            tw = wv & wr;
            tr = arv & arr;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tr) arv <= 1'b0;
        end
        q = rd;
        rs = w ? brs : rrs;
        if (n == 50) begin
            fail_count++;
            conclude();
        end
        @(posedge clk);
        br <= 1'b0;
        rr <= 1'b0;
    endtask
    // Absence of a call is a legal outcome, so no timeout here
    task automatic fire(input logic [9:0] f, input logic l, input logic t);
        int n;
        @(posedge clk);
        flags <= f;
        last <= l;
        touch <= t;
        got = 1'b0;
        for (n = 0; n < 40 && !got; n++) begin
            @(negedge clk);
            got = call;
        end
        @(posedge clk);
        flags <= '0;
        repeat (24) @(posedge clk);
    endtask
    // Mode outputs lag the register write by two edges, copied bits by one
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic irq_return();
        @(posedge clk);
        rreq <= 1'b1;
        @(posedge clk);
        rreq <= 1'b0;
        repeat (30) @(posedge clk);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus(0, 8'h87, '0);
        chk("pctrl reset", q, '0);
        bus(1, 8'hB7, 32'h0000_00FF);
        bus(0, 8'hB7, '0);
        chk("level extra", q, 32'h0000_0013);
        bus(1, 8'hB7, '0);
        bus(1, 8'h87, 32'h0000_00FC);
        settle();
        chk("pctrl bits", 32'({bf, bs, srd, adc, rxs, txs}), 32'h0000_003F);
        bus(1, 8'h87, '0);
        bus(0, 8'h10, '0);
        chk("unmapped", 32'(rs), 32'h0000_0002);
        bus(1, 8'h10, '0);
        chk("unmapped wr", 32'(rs), 32'h0000_0002);
        bus(1, 8'hA7, 32'h0000_0013);
        bus(1, 8'hA8, 32'h0000_00BF);
        foreach (rows[i]) begin
            fire(rows[i].f, 1'b1, 1'b0);
            chk("row call", 32'(got), 32'h1);
            chk("row vector", 32'(vaddr), 32'(rows[i].v));
            chk("row source", 32'(vsrc), 32'(rows[i].s));
            irq_return();
        end
        bus(1, 8'hA8, 32'h0000_003F);
        fire(10'h001, 1'b1, 1'b0);
        chk("gate off", 32'(got), '0);
        bus(1, 8'hA8, 32'h0000_00BF);
        fire(10'h001, 1'b0, 1'b0);
        chk("not last", 32'(got), '0);
        fire(10'h001, 1'b1, 1'b1);
        chk("reg access", 32'(got), '0);
        fire(10'h000, 1'b1, 1'b0);
        chk("no memory", 32'(got), '0);
        fire(10'h001, 1'b1, 1'b0);
        chk("low call", 32'(got), 32'h1);
        @(posedge clk);
        sub <= 1'b1;
        repeat (12) @(posedge clk);
        sub <= 1'b0;
        fire(10'h004, 1'b1, 1'b0);
        chk("same level", 32'(got), '0);
        bus(1, 8'hB8, 32'h0000_0002);
        fire(10'h004, 1'b1, 1'b0);
        chk("high preempts", 32'(vsrc), 32'h2);
        fire(10'h001, 1'b1, 1'b0);
        chk("high kept", 32'(got), '0);
        chk("nest depth", 32'(depth), 32'h2);
        irq_return();
        irq_return();
        bus(1, 8'hB8, '0);
        bus(1, 8'h87, 32'h0000_0001);
        settle();
        chk("idle", 32'({halt, pstop}), 32'h2);
        fire(10'h001, 1'b1, 1'b0);
        chk("idle wake", 32'(got), 32'h1);
        chk("cpu runs", 32'(halt), '0);
        bus(0, 8'h87, '0);
        chk("idle bit", q, '0);
        irq_return();
        bus(1, 8'h87, 32'h0000_0001);
        @(posedge clk);
        irr <= 1'b1;
        @(posedge clk);
        irr <= 1'b0;
        bus(0, 8'hC0, '0);
        chk("restart", 32'(q[5:4]), 32'h3);
        repeat (36) @(posedge clk);
        bus(0, 8'hC0, '0);
        chk("restarted", 32'(q[5:4]), '0);
        bus(1, 8'h87, 32'h0000_0002);
        settle();
        chk("deep", 32'({pstop, udis}), 32'h3);
        chk("detector on", 32'(lsd), 32'h1);
        fire(10'h001, 1'b1, 1'b0);
        chk("deep wake", 32'(got), '0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (24) @(posedge clk);
        rst <= 1'b0;
        chk("deep left", 32'(pstop), '0);
        bus(0, 8'h87, '0);
        chk("pctrl clear", q, '0);
        conclude();
    end
endmodule // interrupt_dispatch_power_modes_tb
`default_nettype wire
